//--- tb/tb.sv
`timescale 1ns/1ps
`include "drdt_params.svh"

module tb;
    //==========================================================
    // stimulus and observation
    localparam int LIMIT = 4000;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ioRd = 1'b0;
    logic ioWr = 1'b0;
    logic [7:0] ioAddr = 8'h00;
    logic [7:0] ioWdata = 8'h00;
    logic [7:0] ioRdata;
    logic [1:0] zeroFlag;
    int n_errors = 0;
    int checked = 0;
    int cyc = 0;
    // byte registers in low-then-high order
    logic [7:0] regAddr [8] = '{`DRDT_ADDR_CNT0_LO, `DRDT_ADDR_CNT0_HI,
        `DRDT_ADDR_RLD0_LO, `DRDT_ADDR_RLD0_HI, `DRDT_ADDR_CNT1_LO,
        `DRDT_ADDR_CNT1_HI, `DRDT_ADDR_RLD1_LO, `DRDT_ADDR_RLD1_HI};

    drdt_timer #(.DIVIDE(20)) dut (
        .mclk(mclk),
        .rst(rst),
        .ioRd(ioRd),
        .ioWr(ioWr),
        .ioAddr(ioAddr),
        .ioWdata(ioWdata),
        .ioRdata(ioRdata),
        .zeroFlag(zeroFlag)
    );

    //==========================================================
    // clock, cycle count and hang guard
    always #2 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors = n_errors + 1;
            $display("timeout after %0d cycles", cyc);
            conclude();
        end
    end

    //==========================================================
    // access tasks: strobe for one edge, then one idle edge
    task wr(input logic [7:0] a, input logic [7:0] d);
        ioWr <= 1'b1;
        ioAddr <= a;
        ioWdata <= d;
        @(posedge mclk);
        ioWr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task rd(input logic [7:0] a, output logic [7:0] d);
        ioRd <= 1'b1;
        ioAddr <= a;
        @(posedge mclk);
        ioRd <= 1'b0;
        @(posedge mclk);
        d = ioRdata; // registered data, settled since the read edge
    endtask : rd

    task chk(input string name, input logic [15:0] exp,
             input logic [15:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task rdchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        rd(a, v);
        chk(name, {8'h00, exp}, {8'h00, v});
    endtask : rdchk

    // low then high read back to back, strobe held across both
    task rdPair(input int c, output logic [7:0] lo, output logic [7:0] hi);
        ioRd <= 1'b1;
        ioAddr <= regAddr[4*c];
        @(posedge mclk);
        ioAddr <= regAddr[4*c+1];
        @(posedge mclk);
        lo = ioRdata;
        ioRd <= 1'b0;
        @(posedge mclk);
        hi = ioRdata;
    endtask : rdPair

    // bounded wait for a zero flag, returns the cycle it was seen
    task waitFlag(input int c, output int t);
        int n;
        n = 0;
        while (zeroFlag[c] !== 1'b1 && n < 1000) begin
            @(posedge mclk);
            n = n + 1;
        end
        t = cyc;
    endtask : waitFlag

    //==========================================================
    // one channel: reload period, flag clear, halt, byte access
    task runChan(input int c, input logic [7:0] rl);
        int t0;
        int t1;
        logic [7:0] v;
        logic [7:0] w;
        wr(regAddr[4*c], 8'h02);
        wr(regAddr[4*c+1], 8'h00);
        wr(regAddr[4*c+2], rl);
        wr(regAddr[4*c+3], 8'h00);
        wr(`DRDT_ADDR_CTRL, 8'h01 << c);
        waitFlag(c, t0);
        rdchk("ctrl flag", `DRDT_ADDR_CTRL, 8'h41 << c);
        rd(regAddr[4*c], v);
        chk("flag cleared", 16'h0000, {15'h0000, zeroFlag[c]});
        rdchk("running high", regAddr[4*c+1], 8'h00);
        waitFlag(c, t1);
        chk("reload period", 16'((rl + 1) * 20), 16'(t1 - t0));
        wr(`DRDT_ADDR_CTRL, 8'h00);
        rdchk("flag kept", `DRDT_ADDR_CTRL, 8'h40 << c);
        rd(regAddr[4*c], v);
        repeat (60) @(posedge mclk);
        rd(regAddr[4*c], w);
        chk("halted count", {8'h00, v}, {8'h00, w});
        wr(regAddr[4*c+1], 8'h5a);
        rdchk("lone high", regAddr[4*c+1], 8'h00);
        wr(regAddr[4*c], 8'h33);
        rdchk("low write", regAddr[4*c], 8'h33);
        rdchk("high kept", regAddr[4*c+1], 8'h5a);
        rdPair(c, v, w);
        chk("pair low", 16'h0033, {8'h00, v});
        chk("pair high", 16'h005a, {8'h00, w});
        $display("test channel %0d done", c);
    endtask : runChan

    task conclude();
        $display("comparisons %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    //==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rdchk("lone high at reset", `DRDT_ADDR_CNT0_HI, 8'hff);
        for (int i = 0; i < 8; i++) begin
            rdchk("reset value", regAddr[i], 8'hff);
        end
        rdchk("ctrl reset", `DRDT_ADDR_CTRL, 8'h00);
        rdchk("unmapped", 8'h11, 8'h00);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wr(regAddr[i], 8'h20 + 8'(i));
        end
        for (int i = 0; i < 8; i++) begin
            rdchk("decode", regAddr[i], 8'h20 + 8'(i));
        end
        $display("test decode done");
        runChan(0, 8'h04);
        runChan(1, 8'h09);
        conclude();
    end
endmodule : tb

//--- verilog/drdt_channel.sv
`timescale 1ns/1ps
`include "drdt_params.svh"

module drdt_channel #(
    parameter int WIDTH = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic tick,
    input wire logic enable,
    input wire drdt_pkg::drdt_sel_t rdSel,
    input wire drdt_pkg::drdt_sel_t wrSel,
    input wire logic [7:0] wdata,
    output logic [WIDTH-1:0] countValue,
    output logic [WIDTH-1:0] reloadValue,
    output logic [7:0] heldHigh,
    output logic zeroEvent
);
    logic [WIDTH-1:0] next_count;
    wire logic decrement = enable && tick;
    wire logic hitZero = decrement && (countValue == WIDTH'(1));
    wire logic atZero = decrement && (countValue == '0);

    // down count; reload on the tick after zero is reached (count at zero reloads)
    always_comb begin
        next_count = countValue;
        if (wrSel.cntLo) begin
            next_count[7:0] = wdata;
        end
        if (wrSel.cntHi) begin
            next_count[15:8] = wdata;
        end
        if (atZero) begin
            next_count = reloadValue;
        end else if (decrement) begin
            next_count = countValue - WIDTH'(1);
        end
    end

    // count, reload and holding registers
    always_ff @(posedge mclk) begin
        if (rst) begin
            countValue <= `DRDT_COUNT_RESET;
            reloadValue <= `DRDT_RELOAD_RESET;
            heldHigh <= 8'hff;
            zeroEvent <= 1'b0;
        end else begin
            countValue <= next_count;
            zeroEvent <= hitZero;
            if (wrSel.rldLo) begin
                reloadValue[7:0] <= wdata;
            end
            if (wrSel.rldHi) begin
                reloadValue[15:8] <= wdata;
            end
            if (rdSel.cntLo) begin
                heldHigh <= countValue[15:8];
            end
        end
    end

    reload_follow_a: assert property (@(posedge mclk) disable iff (rst)
        atZero && !wrSel.cntLo && !wrSel.cntHi
        |=> countValue == $past(reloadValue))
        else $error("count did not reload at zero");
    hold_capture_a: assert property (@(posedge mclk) disable iff (rst)
        rdSel.cntLo |=> heldHigh == $past(countValue[15:8]))
        else $error("high byte not captured on low read");
endmodule : drdt_channel

//--- verilog/drdt_params.svh
`ifndef DRDT_PARAMS_SVH
`define DRDT_PARAMS_SVH
// register byte addresses in i/o space
`define DRDT_ADDR_CNT0_LO 8'h0c
`define DRDT_ADDR_CNT0_HI 8'h0d
`define DRDT_ADDR_RLD0_LO 8'h0e
`define DRDT_ADDR_RLD0_HI 8'h0f
`define DRDT_ADDR_CTRL 8'h10
`define DRDT_ADDR_CNT1_LO 8'h14
`define DRDT_ADDR_CNT1_HI 8'h15
`define DRDT_ADDR_RLD1_LO 8'h16
`define DRDT_ADDR_RLD1_HI 8'h17
// reset values
`define DRDT_COUNT_RESET 16'hffff
`define DRDT_RELOAD_RESET 16'hffff
`define DRDT_CTRL_RESET 8'h00
// control register fields
`define DRDT_CTRL_EN0_BIT 0
`define DRDT_CTRL_EN1_BIT 1
`define DRDT_CTRL_FLAG0_BIT 6
`define DRDT_CTRL_FLAG1_BIT 7
`define DRDT_CTRL_WR_MASK 8'h3f
// system clocks per count tick
`define DRDT_TICK_DIVIDE 20
`endif

//--- verilog/drdt_pkg.sv
package drdt_pkg;
    // one register access from the processor
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } drdt_access_t;

    // per-channel byte selection decoded from the address
    typedef struct packed {
        logic cntLo;
        logic cntHi;
        logic rldLo;
        logic rldHi;
    } drdt_sel_t;
endpackage : drdt_pkg

//--- verilog/drdt_timer.sv
`timescale 1ns/1ps
`include "drdt_params.svh"

//==========================================================
// Overview of operation
// - two channels, each a 16-bit down count read as two bytes
// - reset loads both count values with ffff
// - enabled channel decrements once every twenty system clocks
// - count at zero reloads from the reload value
// - low byte read returns live low and latches live high
// - high byte read returns the latched high byte
// - halted channel takes byte writes in any order; a high read returns the byte latched by the last low read
// - each channel has a 16-bit reload value, reset to ffff
// - channel 0 count bytes at 0c low and 0d high
// - reload bytes at 0e/0f for channel 0, 16/17 for channel 1
// - channel 1 count bytes at 14 low and 15 high
// - count enable bit starts counting, clearing stops it
// - zero sets a flag, cleared by control read then count read
// - reset stops counting and sets counts and reloads to ffff
// - one common tick is the system clock divided by twenty
module drdt_timer #(
    parameter int DIVIDE = `DRDT_TICK_DIVIDE
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic ioRd,
    input wire logic ioWr,
    input wire logic [7:0] ioAddr,
    input wire logic [7:0] ioWdata,
    output logic [7:0] ioRdata,
    output logic [1:0] zeroFlag
);
    //==========================================================
    // access decode
    drdt_pkg::drdt_access_t acc;
    assign acc = '{rd: ioRd, wr: ioWr, addr: ioAddr, wdata: ioWdata};

    wire logic hitCnt0Lo = acc.addr == `DRDT_ADDR_CNT0_LO;
    wire logic hitCnt0Hi = acc.addr == `DRDT_ADDR_CNT0_HI;
    wire logic hitRld0Lo = acc.addr == `DRDT_ADDR_RLD0_LO;
    wire logic hitRld0Hi = acc.addr == `DRDT_ADDR_RLD0_HI;
    wire logic hitCnt1Lo = acc.addr == `DRDT_ADDR_CNT1_LO;
    wire logic hitCnt1Hi = acc.addr == `DRDT_ADDR_CNT1_HI;
    wire logic hitRld1Lo = acc.addr == `DRDT_ADDR_RLD1_LO;
    wire logic hitRld1Hi = acc.addr == `DRDT_ADDR_RLD1_HI;
    wire logic hitCtrl = acc.addr == `DRDT_ADDR_CTRL;

    drdt_pkg::drdt_sel_t hit0;
    drdt_pkg::drdt_sel_t hit1;
    drdt_pkg::drdt_sel_t rdSel0;
    drdt_pkg::drdt_sel_t rdSel1;
    drdt_pkg::drdt_sel_t wrSel0;
    drdt_pkg::drdt_sel_t wrSel1;
    assign hit0 = '{cntLo: hitCnt0Lo, cntHi: hitCnt0Hi,
                    rldLo: hitRld0Lo, rldHi: hitRld0Hi};
    assign hit1 = '{cntLo: hitCnt1Lo, cntHi: hitCnt1Hi,
                    rldLo: hitRld1Lo, rldHi: hitRld1Hi};
    assign rdSel0 = acc.rd ? hit0 : '0;
    assign rdSel1 = acc.rd ? hit1 : '0;
    assign wrSel0 = acc.wr ? hit0 : '0;
    assign wrSel1 = acc.wr ? hit1 : '0;

    //==========================================================
    // common divide-by-twenty tick
    localparam int DW = $clog2(DIVIDE);
    logic [DW-1:0] divCount;
    wire logic tick = divCount == DW'(DIVIDE - 1);

    // free-running prescaler shared by both channels
    always_ff @(posedge mclk) begin
        if (rst) begin
            divCount <= '0;
        end else begin
            divCount <= tick ? '0 : divCount + DW'(1);
        end
    end

    //==========================================================
    // control register: enables, flags, remaining bits stored
    logic [7:0] ctrl;
    logic [1:0] armed;
    wire logic [1:0] countEn = {ctrl[`DRDT_CTRL_EN1_BIT],
                                ctrl[`DRDT_CTRL_EN0_BIT]};
    wire logic ctrlRd = acc.rd && hitCtrl;
    wire logic ctrlWr = acc.wr && hitCtrl;
    logic [1:0] zeroEvt;
    wire logic [1:0] cntRd = {rdSel1.cntLo || rdSel1.cntHi,
                              rdSel0.cntLo || rdSel0.cntHi};
    wire logic [1:0] flagClr = armed & cntRd;
    wire logic [1:0] next_flag = zeroEvt | (zeroFlag & ~flagClr);
    wire logic [7:0] next_ctrlLow = ctrlWr ?
        (acc.wdata & `DRDT_CTRL_WR_MASK) :
        (ctrl & `DRDT_CTRL_WR_MASK);

    // flag set wins over clear; clear needs a control read first
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl <= `DRDT_CTRL_RESET;
            zeroFlag <= 2'b00;
            armed <= 2'b00;
        end else begin
            ctrl <= next_ctrlLow;
            zeroFlag <= next_flag;
            armed <= ctrlRd ? (zeroFlag | zeroEvt) :
                     (armed & ~flagClr);
        end
    end

    //==========================================================
    // the two channels
    logic [15:0] count0;
    logic [15:0] count1;
    logic [15:0] reload0;
    logic [15:0] reload1;
    logic [7:0] held0;
    logic [7:0] held1;

    drdt_channel #(.WIDTH(16)) u_ch0 (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .enable(countEn[0]),
        .rdSel(rdSel0),
        .wrSel(wrSel0),
        .wdata(acc.wdata),
        .countValue(count0),
        .reloadValue(reload0),
        .heldHigh(held0),
        .zeroEvent(zeroEvt[0])
    );

    drdt_channel #(.WIDTH(16)) u_ch1 (
        .mclk(mclk),
        .rst(rst),
        .tick(tick),
        .enable(countEn[1]),
        .rdSel(rdSel1),
        .wrSel(wrSel1),
        .wdata(acc.wdata),
        .countValue(count1),
        .reloadValue(reload1),
        .heldHigh(held1),
        .zeroEvent(zeroEvt[1])
    );

    //==========================================================
    // read data mux, registered one cycle after the read strobe
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (hitCnt0Lo) next_rdata = count0[7:0];
        if (hitCnt0Hi) next_rdata = held0;
        if (hitRld0Lo) next_rdata = reload0[7:0];
        if (hitRld0Hi) next_rdata = reload0[15:8];
        if (hitCnt1Lo) next_rdata = count1[7:0];
        if (hitCnt1Hi) next_rdata = held1;
        if (hitRld1Lo) next_rdata = reload1[7:0];
        if (hitRld1Hi) next_rdata = reload1[15:8];
        if (hitCtrl) next_rdata = {zeroFlag, ctrl[5:0]};
    end

    // read data register
    always_ff @(posedge mclk) begin
        if (rst) begin
            ioRdata <= 8'h00;
        end else if (acc.rd) begin
            ioRdata <= next_rdata;
        end
    end

    //==========================================================
    // checks
    logic [4:0] stillCycles;
    always_ff @(posedge mclk) begin
        if (rst) begin
            stillCycles <= '0;
        end else begin
            stillCycles <= tick ? '0 : stillCycles + 5'h01;
        end
    end

    // byte reads of either channel, low and high
    sequence lowRead0;
        acc.rd && hitCnt0Lo;
    endsequence
    sequence highRead0;
        acc.rd && hitCnt0Hi;
    endsequence
    sequence lowRead1;
        acc.rd && hitCnt1Lo;
    endsequence
    sequence highRead1;
        acc.rd && hitCnt1Hi;
    endsequence
    wire logic anyHit = |{hit0, hit1, hitCtrl};

    // prescaler and counting
    tick_period_a: assert property (@(posedge mclk) disable iff (rst)
        tick |-> ##20 tick)
        else $error("tick period is not twenty clocks");
    tick_spacing_a: assert property (@(posedge mclk) disable iff (rst)
        stillCycles < 5'h14)
        else $error("tick gap too long");
    halted_still_a: assert property (@(posedge mclk) disable iff (rst)
        !countEn[0] && !wrSel0.cntLo && !wrSel0.cntHi
        |=> $stable(count0))
        else $error("halted channel 0 changed");
    halted_still1_a: assert property (@(posedge mclk) disable iff (rst)
        !countEn[1] && !wrSel1.cntLo && !wrSel1.cntHi
        |=> $stable(count1))
        else $error("halted channel 1 changed");
    step_down_a: assert property (@(posedge mclk) disable iff (rst)
        countEn[1] && tick && count1 != 16'h0000 && !wrSel1.cntLo
        && !wrSel1.cntHi |=> count1 == $past(count1) - 16'h0001)
        else $error("channel 1 did not decrement");
    step_down0_a: assert property (@(posedge mclk) disable iff (rst)
        countEn[0] && tick && count0 != 16'h0000 && !wrSel0.cntLo
        && !wrSel0.cntHi |=> count0 == $past(count0) - 16'h0001)
        else $error("channel 0 did not decrement");
    zero_event_a: assert property (@(posedge mclk) disable iff (rst)
        zeroEvt[0] |-> count0 == 16'h0000)
        else $error("zero event 0 without zero count");
    zero_event1_a: assert property (@(posedge mclk) disable iff (rst)
        zeroEvt[1] |-> count1 == 16'h0000)
        else $error("zero event 1 without zero count");

    // read path
    low_data_a: assert property (@(posedge mclk) disable iff (rst)
        lowRead0 |=> ioRdata == $past(count0[7:0]))
        else $error("low byte read not live");
    count1_seen_a: assert property (@(posedge mclk) disable iff (rst)
        lowRead1 |=> ioRdata == $past(count1[7:0]))
        else $error("channel 1 low byte read wrong");
    paired_read_a: assert property (@(posedge mclk) disable iff (rst)
        lowRead0 ##1 highRead0 |=> ioRdata == $past(count0[15:8], 2))
        else $error("high byte read not consistent");
    paired_read1_a: assert property (@(posedge mclk) disable iff (rst)
        lowRead1 ##1 highRead1 |=> ioRdata == $past(count1[15:8], 2))
        else $error("channel 1 high byte not consistent");
    lone_high_a: assert property (@(posedge mclk) disable iff (rst)
        highRead0 |=> ioRdata == $past(held0))
        else $error("high read not from holding register");
    lone_high1_a: assert property (@(posedge mclk) disable iff (rst)
        highRead1 |=> ioRdata == $past(held1))
        else $error("channel 1 high read not held byte");
    reload_seen_a: assert property (@(posedge mclk) disable iff (rst)
        acc.rd && hitRld0Lo |=> ioRdata == $past(reload0[7:0]))
        else $error("reload low byte read wrong");
    reload1_seen_a: assert property (@(posedge mclk) disable iff (rst)
        acc.rd && hitRld1Hi |=> ioRdata == $past(reload1[15:8]))
        else $error("channel 1 reload high read wrong");
    unmapped_read_a: assert property (@(posedge mclk) disable iff (rst)
        acc.rd && !anyHit |=> ioRdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (@(posedge mclk) disable iff (rst)
        !acc.rd |=> $stable(ioRdata))
        else $error("read data changed without a read");

    // writes and control
    low_write_a: assert property (@(posedge mclk) disable iff (rst)
        wrSel0.cntLo && !countEn[0] |=> count0[15:8] ==
        $past(count0[15:8]) && count0[7:0] == $past(acc.wdata))
        else $error("low write disturbed other byte");
    high_write_a: assert property (@(posedge mclk) disable iff (rst)
        wrSel1.cntHi && !countEn[1] |=> count1[7:0] ==
        $past(count1[7:0]) && count1[15:8] == $past(acc.wdata))
        else $error("high write disturbed other byte");
    rld_low_write_a: assert property (@(posedge mclk) disable iff (rst)
        wrSel0.rldLo |=> reload0[7:0] == $past(acc.wdata))
        else $error("reload low byte not written");
    reload_write_a: assert property (@(posedge mclk) disable iff (rst)
        wrSel1.rldHi |=> reload1[15:8] == $past(acc.wdata))
        else $error("reload high byte not written");
    ctrl_write_a: assert property (@(posedge mclk) disable iff (rst)
        ctrlWr |=> countEn == $past(acc.wdata[1:0]))
        else $error("count enables not written");
    ctrl_read_a: assert property (@(posedge mclk) disable iff (rst)
        ctrlRd |=> ioRdata[7:6] == $past(zeroFlag)
        && ioRdata[1:0] == $past(countEn))
        else $error("control read wrong");

    // zero flags and reset
    flag_set_a: assert property (@(posedge mclk) disable iff (rst)
        zeroEvt[0] |=> zeroFlag[0])
        else $error("zero flag not set");
    flag_set1_a: assert property (@(posedge mclk) disable iff (rst)
        zeroEvt[1] |=> zeroFlag[1])
        else $error("zero flag 1 not set");
    flag_clear_a: assert property (@(posedge mclk) disable iff (rst)
        armed[0] && cntRd[0] && !zeroEvt[0] |=> !zeroFlag[0])
        else $error("zero flag 0 not cleared");
    flag_stays_a: assert property (@(posedge mclk) disable iff (rst)
        zeroFlag[1] && !(armed[1] && cntRd[1]) |=> zeroFlag[1])
        else $error("zero flag 1 dropped early");
    reset_vals_a: assert property (@(posedge mclk)
        rst |=> count0 == 16'hffff && reload1 == 16'hffff
        && countEn == 2'b00)
        else $error("reset values wrong");
    reset_vals1_a: assert property (@(posedge mclk)
        rst |=> count1 == 16'hffff && reload0 == 16'hffff
        && zeroFlag == 2'b00 && ioRdata == 8'h00)
        else $error("reset values of channel 1 wrong");
endmodule : drdt_timer
